// >>> include/fpc_pkg.sv
// Purpose: Shared constants, code tables and helpers of the Fast Ethernet coding path.
// Assumes: One line bit per ref_clk cycle; every slower rate is an enable pulse.
// Notes: Code groups are written MSB first, and bit 4 leaves the serializer first.
//
// Notes on behaviour
// - MAC nibbles become a serial 125 MHz bit stream before line coding.
// - Serial stream is 4B/5B coded first, then scrambled.
// - Scrambled stream goes NRZ to NRZI, then out as MLT3 levels.
// - Receive runs MLT3 to NRZI, recovery, NRZ, descramble, decode, deserialize.
// - Receive bit timing follows NRZI transitions and drives the NRZI to NRZ step.
// - Decoded receive data leaves as parallel nibbles toward the MAC.
// - Synthesizer makes 125, 31.25, 25 and 10 MHz timing from a 25 MHz reference.
// - In reduced-pin mode the reference is a 50 MHz clock instead.
// - Transmit scrambler is an eleven-bit linear feedback shift register.
// - Scrambler key sequence is maximal length, repeating after 2047 bits.
// - Descrambler uses the same key sequence as the transmit scrambler.
// - Fiber mode bypasses scrambling and MLT3 both ways; 4B/5B and NRZI stay.
// - Fiber mode skips auto-negotiation and keeps automatic crossover off.
// - Port runs fiber mode when signal detect is above 1 V, else twisted pair.
// - Signal detect between 1 V and 1.8 V means no signal and far-end fault.
// - Signal detect above 2.2 V means signal present and no far-end fault.
// - During a fault, idle gaps carry 84 ones then one zero, repeatedly.
// - Far-end fault generation is on after reset and can be switched off.

package fpc_pkg;

  // ------------------------------------------------------------------
  // Rates, in kHz as figures for the divider arithmetic
  // ------------------------------------------------------------------
  localparam logic [16:0] BIT_RATE_KHZ = 17'h1_e848;
  localparam logic [16:0] NIBBLE_KHZ = 17'h0_61a8;
  localparam logic [16:0] SLOW_31_KHZ = 17'h0_7a12;
  localparam logic [16:0] SLOW_10_KHZ = 17'h0_2710;
  localparam int BITS_PER_NIBBLE = int'(BIT_RATE_KHZ / NIBBLE_KHZ);

  // ------------------------------------------------------------------
  // Code groups
  // ------------------------------------------------------------------
  localparam int NIBBLE_W = 4;
  localparam int CG_BITS = 5;
  localparam logic [4:0] CG_IDLE = 5'h1f;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0d;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_H = 5'h04;
  localparam logic [3:0] PREAMBLE_NIB = 4'h5;
  localparam logic [4:0] CG_DATA [16] = '{
    5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d
  };

  // ------------------------------------------------------------------
  // Far-end fault pattern
  // ------------------------------------------------------------------
  localparam int FEF_ONES = 84;
  localparam int FEF_GROUPS = (FEF_ONES + 1) / CG_BITS;
  localparam logic [4:0] FEF_LAST_CG = 5'h1e;

  // ------------------------------------------------------------------
  // Scrambler and signal-detect comparator layout
  // ------------------------------------------------------------------
  localparam int SCR_WIDTH = 11;
  localparam int SCR_TAP = 9;
  localparam logic [10:0] SCR_SEED = 11'h7ff;
  localparam int FSD_1V = 0;
  localparam int FSD_1V8 = 1;
  localparam int FSD_2V2 = 2;

  // ------------------------------------------------------------------
  // Line levels and states
  // ------------------------------------------------------------------
  localparam logic [1:0] MLT_ZERO = 2'b00;
  localparam logic [1:0] MLT_PLUS = 2'b01;
  localparam logic [1:0] MLT_MINUS = 2'b11;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_SSDK = 4'b0010,
    TX_DATA = 4'b0100,
    TX_ESDR = 4'b1000
  } fpc_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_FRAME = 2'b10
  } fpc_rx_state_t;

  // Returns {valid, nibble}; valid is low for every non-data group.
  function automatic logic [4:0] fpc_decode5(input logic [4:0] code);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (CG_DATA[i] == code) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction

  function automatic logic [1:0] fpc_mlt_level(input logic [1:0] phase);
    logic [1:0] lvl;
    case (phase)
      2'd1: lvl = MLT_PLUS;
      2'd3: lvl = MLT_MINUS;
      default: lvl = MLT_ZERO;
    endcase
    return lvl;
  endfunction

endpackage

// >>> verilog/fpc_lfsr.sv
// Purpose: Eleven-bit key generator shared by the scrambler and descrambler.
// Assumes: shiftEn marks one line bit; loadEn feeds received key bits in.
// Notes: Key is combinational from the state so it pairs with the current bit.
`timescale 1ns/1ps
`default_nettype none

module fpc_lfsr #(
  parameter int WIDTH = fpc_pkg::SCR_WIDTH,
  parameter int TAP = fpc_pkg::SCR_TAP
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic shiftEn,
  input wire logic loadEn,
  input wire logic loadBit,
  // Key
  output logic key
);
  import fpc_pkg::*;

  logic [WIDTH-1:0] state_r;

  generate
    if (WIDTH != SCR_WIDTH || TAP >= WIDTH || TAP < 1) begin : g_bad
      $error("fpc_lfsr: the seed and the tap need WIDTH 11 and 1 <= TAP < WIDTH");
    end
  endgenerate

  // Taps at x^11 and x^9 give the maximal 2047-bit cycle.
  assign key = state_r[WIDTH-1] ^ state_r[TAP-1];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= SCR_SEED;
    end else if (shiftEn) begin
      // While loading, received key bits replace the feedback.
      state_r <= {state_r[WIDTH-2:0], loadEn ? loadBit : key};
    end
  end

endmodule
`default_nettype wire

// >>> verilog/fpc_coding.sv
// Purpose: Transmit and receive coding path of one Fast Ethernet port, with fiber mode.
// Assumes: ref_clk cycle stands for one 125 MHz line bit; pins are synchronous.
// Notes: Analog slicing is outside; line levels and comparator results arrive digital.
`timescale 1ns/1ps
`default_nettype none

module fpc_coding #(
  parameter int CDR_HOLD = 32,
  parameter int LOCK_BITS = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Reference oscillator
  input wire logic refTick,
  input wire logic rmiiMode,
  // Timing enables
  output logic tick125,
  output logic tick31p25,
  output logic tick25,
  output logic tick10,
  output logic synthLocked,
  // MAC transmit
  input wire logic txEn,
  input wire logic txEr,
  input wire logic [fpc_pkg::NIBBLE_W-1:0] txData,
  // MAC receive
  output logic rxStb,
  output logic rxDv,
  output logic rxEr,
  output logic [fpc_pkg::NIBBLE_W-1:0] rxData,
  // Line
  output logic [1:0] txMlt,
  output logic txFiber,
  input wire logic [1:0] rxMlt,
  input wire logic rxFiber,
  // Fiber detect and configuration
  input wire logic [2:0] fiberSignalDetectIn,
  input wire logic fefDisable,
  input wire logic autoNegReq,
  input wire logic autoMdixReq,
  // Status
  output logic fiberMode,
  output logic fiberSignal,
  output logic farEndFault,
  output logic autoNegEn,
  output logic autoMdixEn,
  output logic rxLocked,
  output logic rxCodeErr
);
  import fpc_pkg::*;

  localparam int CW = $clog2(CDR_HOLD + 1);
  localparam int LW = $clog2(LOCK_BITS + 1);
  localparam logic [CW-1:0] CDR_MAX = CW'(CDR_HOLD);
  localparam logic [LW-1:0] LOCK_MAX = LW'(LOCK_BITS);
  localparam logic [16:0] SYN_INC [2] = '{SLOW_31_KHZ, SLOW_10_KHZ};
  localparam logic [2:0] BIT_LAST = 3'(BITS_PER_NIBBLE - 1);
  localparam logic [4:0] FEF_LAST = 5'(FEF_GROUPS - 1);

  generate
    if (CDR_HOLD < 2 || LOCK_BITS < SCR_WIDTH || BITS_PER_NIBBLE != CG_BITS) begin : g_bad
      $error("fpc_coding: CDR_HOLD >= 2 and LOCK_BITS >= 11 are needed");
    end
  endgenerate

  // ------------------------------------------------------------------
  // Clock synthesizer
  // ------------------------------------------------------------------
  logic refHalf_r;
  logic baseTick;
  logic [3:0] refGap_r;
  logic [16:0] synAcc_r [2];
  logic [16:0] synSum [2];
  logic [16:0] synNxt [2];
  logic [1:0] synHit;

  // A 50 MHz reference is halved so both modes check against the same 25 MHz base.
  assign baseTick = refTick & (!rmiiMode | refHalf_r);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_syn
      assign synSum[g] = synAcc_r[g] + SYN_INC[g];
      assign synHit[g] = synSum[g] >= BIT_RATE_KHZ;
      assign synNxt[g] = synHit[g] ? synSum[g] - BIT_RATE_KHZ : synSum[g];
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      synAcc_r <= '{17'h0_0000, 17'h0_0000};
      tick125 <= 1'b0;
      tick31p25 <= 1'b0;
      tick10 <= 1'b0;
    end else begin
      synAcc_r <= synNxt;
      tick125 <= 1'b1;
      tick31p25 <= synHit[0];
      tick10 <= synHit[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      refHalf_r <= 1'b0;
      refGap_r <= 4'h0;
      synthLocked <= 1'b0;
    end else begin
      if (refTick && rmiiMode) begin
        refHalf_r <= !refHalf_r;
      end
      if (baseTick) begin
        refGap_r <= 4'h0;
        synthLocked <= refGap_r == 4'(BIT_LAST);
      end else if (refGap_r != 4'hf) begin
        refGap_r <= refGap_r + 4'h1;
      end else begin
        synthLocked <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Fiber detect and port configuration
  // ------------------------------------------------------------------
  logic fefOn_r;
  logic fefSend;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fiberMode <= 1'b0;
      farEndFault <= 1'b0;
      fiberSignal <= 1'b0;
      fefOn_r <= 1'b1;
      autoNegEn <= 1'b0;
      autoMdixEn <= 1'b0;
    end else begin
      fiberMode <= fiberSignalDetectIn[FSD_1V];
      farEndFault <= fiberSignalDetectIn[FSD_1V] & !fiberSignalDetectIn[FSD_1V8];
      // The band between 1.8 V and 2.2 V keeps the last decision as hysteresis.
      if (fiberSignalDetectIn[FSD_2V2]) begin
        fiberSignal <= 1'b1;
      end else if (!fiberSignalDetectIn[FSD_1V8]) begin
        fiberSignal <= 1'b0;
      end
      fefOn_r <= !fefDisable;
      autoNegEn <= autoNegReq & !fiberMode;
      autoMdixEn <= autoMdixReq & !fiberMode;
    end
  end

  assign fefSend = farEndFault & fefOn_r & fiberMode;

  // ------------------------------------------------------------------
  // Transmit: serializer and 4B/5B encoder
  // ------------------------------------------------------------------
  fpc_tx_state_t txState_r;
  fpc_tx_state_t txState_nxt;
  logic [2:0] txBitCnt_r;
  logic groupStart;
  logic [4:0] txShift_r;
  logic [4:0] txCode;
  logic [4:0] fefGrp_r;

  assign groupStart = txBitCnt_r == BIT_LAST;

  always_comb begin
    txState_nxt = txState_r;
    txCode = CG_IDLE;
    case (txState_r)
      TX_IDLE: begin
        if (txEn) begin
          txCode = CG_J;
          txState_nxt = TX_SSDK;
        end else if (fefSend && fefGrp_r == FEF_LAST) begin
          txCode = FEF_LAST_CG;
        end
      end
      TX_SSDK: begin
        txCode = CG_K;
        txState_nxt = TX_DATA;
      end
      TX_DATA: begin
        if (txEn) begin
          txCode = txEr ? CG_H : CG_DATA[txData];
        end else begin
          txCode = CG_T;
          txState_nxt = TX_ESDR;
        end
      end
      TX_ESDR: begin
        txCode = CG_R;
        txState_nxt = TX_IDLE;
      end
      default: begin
        txState_nxt = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txBitCnt_r <= 3'd0;
      txShift_r <= CG_IDLE;
      txState_r <= TX_IDLE;
      tick25 <= 1'b0;
    end else begin
      // The MAC nibble is sampled once per five line bits.
      txBitCnt_r <= groupStart ? 3'd0 : txBitCnt_r + 3'd1;
      tick25 <= groupStart;
      if (groupStart) begin
        txShift_r <= txCode;
        txState_r <= txState_nxt;
      end else begin
        txShift_r <= {txShift_r[3:0], 1'b0};
      end
    end
  end

  // The all-ones idle already carries the ones; only the last bit of each run is cleared.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fefGrp_r <= 5'd0;
    end else if (groupStart) begin
      if (txState_r == TX_IDLE && !txEn && fefSend) begin
        fefGrp_r <= (fefGrp_r == FEF_LAST) ? 5'd0 : fefGrp_r + 5'd1;
      end else begin
        fefGrp_r <= 5'd0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Transmit: scrambler, NRZI and MLT3
  // ------------------------------------------------------------------
  logic txKey;
  logic scrBit;
  logic txNrzi_r;
  logic [1:0] mltPhase_r;
  logic [1:0] mltPhaseNxt;

  fpc_lfsr u_tx_lfsr (
    .ref_clk(ref_clk),
    .rst(rst),
    .shiftEn(1'b1),
    .loadEn(1'b0),
    .loadBit(1'b0),
    .key(txKey)
  );

  assign scrBit = fiberMode ? txShift_r[4] : txShift_r[4] ^ txKey;
  assign mltPhaseNxt = txNrzi_r ? mltPhase_r + 2'd1 : mltPhase_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txNrzi_r <= 1'b0;
      mltPhase_r <= 2'd0;
      txMlt <= MLT_ZERO;
      txFiber <= 1'b0;
    end else begin
      txNrzi_r <= txNrzi_r ^ scrBit;
      if (!fiberMode) begin
        mltPhase_r <= mltPhaseNxt;
      end
      txMlt <= fiberMode ? MLT_ZERO : fpc_mlt_level(mltPhaseNxt);
      txFiber <= fiberMode ? txNrzi_r : 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Receive: MLT3 to NRZI, bit recovery, NRZI to NRZ
  // ------------------------------------------------------------------
  logic [1:0] rxPrevMlt_r;
  logic rxNrziLvl;
  logic rxNrziPrev_r;
  logic rxNrz;
  logic [CW-1:0] rxQuiet_r;
  logic rxCdrOk_r;

  // A level change on the three-level line is an NRZI one.
  assign rxNrziLvl = fiberMode ? rxFiber : rxMlt != rxPrevMlt_r;
  assign rxNrz = rxNrziLvl ^ rxNrziPrev_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxPrevMlt_r <= MLT_ZERO;
      rxNrziPrev_r <= 1'b0;
      rxQuiet_r <= '0;
      rxCdrOk_r <= 1'b0;
    end else begin
      rxPrevMlt_r <= rxMlt;
      rxNrziPrev_r <= rxNrziLvl;
      // Long runs without a transition mean the bit timing can no longer be trusted.
      if (rxNrz) begin
        rxQuiet_r <= '0;
      end else if (rxQuiet_r != CDR_MAX) begin
        rxQuiet_r <= rxQuiet_r + CW'(1);
      end
      rxCdrOk_r <= rxQuiet_r < CDR_MAX;
    end
  end

  // ------------------------------------------------------------------
  // Receive: descrambler
  // ------------------------------------------------------------------
  logic rxKey;
  logic rxScrLock_r;
  logic [LW-1:0] rxMatch_r;
  logic rxPlain;

  // Idle is all ones, so while hunting the received bit inverted is the key itself.
  fpc_lfsr u_rx_lfsr (
    .ref_clk(ref_clk),
    .rst(rst),
    .shiftEn(1'b1),
    .loadEn(!rxScrLock_r),
    .loadBit(!rxNrz),
    .key(rxKey)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxScrLock_r <= 1'b0;
      rxMatch_r <= '0;
    end else if (fiberMode || !rxCdrOk_r) begin
      rxScrLock_r <= 1'b0;
      rxMatch_r <= '0;
    end else if (!rxScrLock_r) begin
      if (rxKey == !rxNrz) begin
        rxMatch_r <= rxMatch_r + LW'(1);
        rxScrLock_r <= rxMatch_r == LOCK_MAX - LW'(1);
      end else begin
        rxMatch_r <= '0;
      end
    end
  end

  always_comb begin
    if (fiberMode) begin
      rxPlain = rxCdrOk_r ? rxNrz : 1'b1;
    end else begin
      rxPlain = (rxScrLock_r && rxCdrOk_r) ? rxNrz ^ rxKey : 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxLocked <= 1'b0;
    end else begin
      rxLocked <= rxCdrOk_r & (fiberMode | rxScrLock_r);
    end
  end

  // ------------------------------------------------------------------
  // Receive: alignment, 4B/5B decoder and nibble output
  // ------------------------------------------------------------------
  fpc_rx_state_t rxState_r;
  fpc_rx_state_t rxState_nxt;
  logic [9:0] rxWin_r;
  logic [9:0] rxWinNxt;
  logic [2:0] rxCnt_r;
  logic [4:0] rxDec;
  logic rxEmit;
  logic rxEmitDv;
  logic rxEmitEr;
  logic [3:0] rxEmitData;

  assign rxWinNxt = {rxWin_r[8:0], rxPlain};
  assign rxDec = fpc_decode5(rxWinNxt[4:0]);

  always_comb begin
    rxState_nxt = rxState_r;
    rxEmit = 1'b0;
    rxEmitDv = 1'b0;
    rxEmitEr = 1'b0;
    rxEmitData = 4'h0;
    case (rxState_r)
      RX_IDLE: begin
        if (rxWinNxt == {CG_J, CG_K}) begin
          rxState_nxt = RX_FRAME;
          rxEmit = 1'b1;
          rxEmitDv = 1'b1;
          rxEmitData = PREAMBLE_NIB;
        end
      end
      RX_FRAME: begin
        if (rxCnt_r == BIT_LAST) begin
          rxEmit = 1'b1;
          if (rxDec[4]) begin
            rxEmitDv = 1'b1;
            rxEmitData = rxDec[3:0];
          end else if (rxWinNxt[4:0] == CG_T) begin
            rxState_nxt = RX_IDLE;
          end else if (rxWinNxt[4:0] == CG_IDLE) begin
            // Idle inside a frame is a premature end and is reported.
            rxState_nxt = RX_IDLE;
            rxEmitEr = 1'b1;
          end else begin
            rxEmitDv = 1'b1;
            rxEmitEr = 1'b1;
          end
        end
      end
      default: begin
        rxState_nxt = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxWin_r <= '0;
      rxCnt_r <= 3'd0;
      rxState_r <= RX_IDLE;
    end else begin
      rxWin_r <= rxWinNxt;
      rxState_r <= rxState_nxt;
      if (rxState_r != RX_FRAME || rxCnt_r == BIT_LAST) begin
        rxCnt_r <= 3'd0;
      end else begin
        rxCnt_r <= rxCnt_r + 3'd1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxStb <= 1'b0;
      rxDv <= 1'b0;
      rxEr <= 1'b0;
      rxData <= 4'h0;
      rxCodeErr <= 1'b0;
    end else begin
      rxStb <= rxEmit;
      rxCodeErr <= rxEmit & rxEmitEr;
      if (rxEmit) begin
        rxDv <= rxEmitDv;
        rxEr <= rxEmitEr;
        rxData <= rxEmitData;
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_nibble_period: assert property (@(posedge ref_clk) disable iff (rst)
    tick25 |=> !tick25 [*4] ##1 tick25)
    else $error("nibble enable is not every five bits");

  a_start_delim: assert property (@(posedge ref_clk) disable iff (rst)
    (txState_r == TX_IDLE && groupStart && txEn) |=> txShift_r == CG_J ##5 txShift_r == CG_K)
    else $error("start of frame is not J then K");

  a_mlt_step: assert property (@(posedge ref_clk) disable iff (rst)
    (!fiberMode && $past(fiberMode) == 1'b0 && txNrzi_r) |=> txMlt != $past(txMlt))
    else $error("MLT3 level held on an NRZI one");

  a_fiber_bypass: assert property (@(posedge ref_clk) disable iff (rst)
    fiberMode |=> (txMlt == MLT_ZERO && txFiber == $past(txNrzi_r)))
    else $error("fiber transmit does not carry plain NRZI");

  a_fault_band: assert property (@(posedge ref_clk) disable iff (rst)
    (fiberSignalDetectIn == 3'b001) |=> (farEndFault && fiberMode && !fiberSignal))
    else $error("low signal-detect band without fault");

  a_signal_band: assert property (@(posedge ref_clk) disable iff (rst)
    (fiberSignalDetectIn == 3'b111) |=> (fiberSignal && !farEndFault && fiberMode))
    else $error("high signal-detect band not seen as signal");

  a_fiber_no_an: assert property (@(posedge ref_clk) disable iff (rst)
    fiberMode |=> (!autoNegEn && !autoMdixEn))
    else $error("negotiation or crossover left on in fiber mode");

  a_fef_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (groupStart && txState_r == TX_IDLE && !txEn && fefSend && fefGrp_r == FEF_LAST)
    |=> txShift_r == FEF_LAST_CG ##5 txShift_r[4])
    else $error("fault pattern does not end its run of ones with a zero");

  a_fef_default: assert property (@(posedge ref_clk)
    rst |=> fefOn_r)
    else $error("fault generation not enabled after reset");

  a_rx_spacing: assert property (@(posedge ref_clk) disable iff (rst)
    rxStb |=> !rxStb [*4])
    else $error("receive nibbles closer than one code group");

endmodule
`default_nettype wire

// >>> testbench/fpc_line_peer.sv
// Purpose: Far end of the line, returning what the port sends.
// Assumes: One line bit per ref_clk cycle.
// Notes: One cycle of delay stands for the cable.
`timescale 1ns/1ps
`default_nettype none
module fpc_line_peer (
  // Clock
  input wire logic ref_clk,
  // From the port
  input wire logic [1:0] txMlt,
  input wire logic txFiber,
  // To the port
  output logic [1:0] rxMlt,
  output logic rxFiber
);
  always_ff @(posedge ref_clk) begin
    rxMlt <= txMlt;
    rxFiber <= txFiber;
  end
endmodule
`default_nettype wire

// >>> testbench/fpc_coding_tb_top.sv
// Purpose: Self-checking bench of the coding path in line loopback.
// Assumes: One line bit per ref_clk cycle.
// Notes: A short lock count keeps the run brief.
`timescale 1ns/1ps
`default_nettype none
module fpc_coding_tb_top;
  import fpc_pkg::*;
  logic ref_clk = 0, rst = 1, refTick = 0, rmiiMode = 0, txEn = 0, txEr = 0;
  logic fefDisable = 0, txFiber, rxFiber, rxStb, rxDv, rxEr, rxLocked, prevF = 0;
  logic tick125, tick25, synthLocked, fiberMode, fiberSignal, farEndFault;
  logic tick31p25, tick10, rxCodeErr;
  logic autoNegEn, autoMdixEn;
  logic [3:0] txData = 4'h0, rxData;
  logic [2:0] fsd = 3'h0;
  logic [1:0] txMlt, rxMlt;
  logic [3:0] rxQ[$];
  int n_mismatch = 0, samples_checked = 0, run = 0, lastRun = 0, rc = 0, nErr = 0;

  always #50 ref_clk = ~ref_clk;

  fpc_coding #(.CDR_HOLD(32), .LOCK_BITS(12)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .refTick(refTick), .rmiiMode(rmiiMode),
    .tick125(tick125), .tick31p25(tick31p25), .tick25(tick25), .tick10(tick10),
    .synthLocked(synthLocked), .txEn(txEn), .txEr(txEr), .txData(txData),
    .rxStb(rxStb), .rxDv(rxDv), .rxEr(rxEr), .rxData(rxData), .txMlt(txMlt),
    .txFiber(txFiber), .rxMlt(rxMlt), .rxFiber(rxFiber),
    .fiberSignalDetectIn(fsd), .fefDisable(fefDisable), .autoNegReq(1'b1),
    .autoMdixReq(1'b1), .fiberMode(fiberMode), .fiberSignal(fiberSignal),
    .farEndFault(farEndFault), .autoNegEn(autoNegEn), .autoMdixEn(autoMdixEn),
    .rxLocked(rxLocked), .rxCodeErr(rxCodeErr));

  fpc_line_peer peer_u (.ref_clk(ref_clk), .txMlt(txMlt), .txFiber(txFiber),
    .rxMlt(rxMlt), .rxFiber(rxFiber));

  // ----------------------------------------
  // Reference ticks and line monitor
  // ----------------------------------------
  // In reduced-pin mode ticks come at gaps of 2 and 3, every second one counts.
  always @(posedge ref_clk) begin
    rc <= (rc == 4) ? 0 : rc + 1;
    refTick <= (rc == 0) || (rmiiMode && rc == 2);
  end

  always @(negedge ref_clk) begin
    // Flagged groups are counted apart, so a lost error flag shows up as an extra nibble.
    if (rxStb && rxDv && !rxEr) rxQ.push_back(rxData);
    if (rxStb && rxCodeErr) nErr++;
    if (txFiber ^ prevF) run++;
    else begin
      if (run > 0) lastRun = run;
      run = 0;
    end
    prevF = txFiber;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic t_detect;
    logic [2:0] cd[5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h3};
    logic [4:0] ex[5] = '{5'h03, 5'h18, 5'h10, 5'h14, 5'h14};
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      fsd <= cd[i];
      cyc(4);
      @(negedge ref_clk);
      chk({fiberMode, farEndFault, fiberSignal, autoNegEn, autoMdixEn}, ex[i]);
    end
  endtask

  task automatic t_frame(input logic fib);
    @(posedge ref_clk);
    fsd <= fib ? 3'h7 : 3'h0;
    cyc(300);
    @(negedge ref_clk);
    chk(rxLocked, 1);
    rxQ.delete();
    nErr = 0;
    do @(negedge ref_clk); while (tick25 !== 1'b1);
    // The first two groups become the start delimiter, so their data is ignored.
    // The last data group is sent as an error and must come back flagged.
    for (int i = 0; i < 18; i++) begin
      @(posedge ref_clk);
      txEn <= 1;
      txEr <= (i == 17);
      txData <= 4'(i);
      cyc(4);
    end
    @(posedge ref_clk);
    txEn <= 0;
    txEr <= 0;
    cyc(80);
    @(negedge ref_clk);
    chk(fib ? txMlt : {1'b0, txFiber}, 0);
    chk(8'(nErr), 1);
    chk(8'(rxQ.size()), 16);
    foreach (rxQ[k]) chk(rxQ[k], k == 0 ? 4'h5 : 4'(k + 1));
  endtask

  task automatic t_rates;
    int n31 = 0;
    int n10 = 0;
    repeat (100) begin
      @(negedge ref_clk);
      n31 += int'(tick31p25);
      n10 += int'(tick10);
    end
    chk(8'(n31), 25);
    chk(8'(n10), 8);
  endtask

  task automatic t_fef;
    @(posedge ref_clk);
    fsd <= 3'h1;
    cyc(400);
    chk(8'(lastRun), 84);
    fefDisable <= 1;
    cyc(300);
    chk(8'(run > 150), 1);
    fefDisable <= 0;
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    cyc(11);
    @(negedge ref_clk);
    chk({6'h0, txMlt}, 0);
    @(posedge ref_clk);
    rst <= 0;
    cyc(40);
    @(negedge ref_clk);
    chk({tick125, synthLocked}, 2'b11);
    t_rates();
    t_detect();
    t_frame(1);
    t_frame(0);
    t_fef();
    rmiiMode <= 1;
    cyc(40);
    @(negedge ref_clk);
    chk(synthLocked, 1);
    stop_test();
  end

  initial begin
    cyc(6000);
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
